//--- hw/label_tag_pkg.sv
package label_tag_pkg;
  localparam int          ADDR_W         = 4;
  localparam int          CNT_W          = 16;
  localparam int          TAG_W          = 32;
  // Register offsets
  localparam logic [3:0]  REG_START_MODE = 4'h0;
  localparam logic [3:0]  REG_SECOND_CTL = 4'h1;
  localparam logic [3:0]  REG_OUT_CFG    = 4'h2;
  localparam logic [3:0]  REG_COMMAND    = 4'h3;
  localparam logic [3:0]  REG_COUNTS     = 4'h4;
  localparam logic [3:0]  REG_STATUS     = 4'h5;
  // Field positions
  localparam int          SECOND_RUN_BIT = 0;
  localparam int          SECOND_EXT_BIT = 1;
  localparam int          OUT_EN_BIT     = 0;
  localparam int          OUT0_FN_LSB    = 1;
  localparam int          OUT1_FN_LSB    = 3;
  localparam int          CMD_START_BIT  = 0;
  localparam int          CMD_SECOND_BIT = 1;
  // Reset values
  localparam logic [1:0]  START_MODE_RST = 2'h0;
  localparam logic [4:0]  OUT_CFG_RST    = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
  typedef enum logic [1:0] {
    label_mode_off             = 2'h0,
    label_mode_internal        = 2'h1,
    label_mode_ext_in1_rising  = 2'h3,
    label_mode_ext_in2_rising  = 2'h2
  } label_mode_t;
  typedef enum logic [1:0] {
    output_fn_none         = 2'h0,
    output_fn_start_label  = 2'h1,
    output_fn_second_label = 2'h2
  } output_fn_t;
endpackage

//--- hw/tag_fifo.sv
`timescale 1ns/1ps
module tag_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (fill < (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- hw/sync_label_tagger.sv
`timescale 1ns/1ps
module sync_label_tagger
  import label_tag_pkg::*;
#(
  parameter int N_MOD  = 4,
  parameter int DATA_W = 32,
  parameter int DEPTH  = 32
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Register port
  input  wire logic [label_tag_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [31:0]               reg_rdata,
  // Module words
  input  wire logic [N_MOD-1:0]          mod_valid,
  input  wire logic [N_MOD*DATA_W-1:0]   mod_data,
  output logic      [N_MOD-1:0]          mod_ready,
  // Host stream
  output logic                           host_valid,
  input  wire logic                      host_ready,
  output logic      [DATA_W-1:0]         host_data,
  output logic      [label_tag_pkg::TAG_W-1:0] host_tag,
  output logic      [7:0]                host_module,
  // Synchronization connector
  input  wire logic                      sync_input_first,
  input  wire logic                      sync_input_second,
  output logic                           sync_output_first,
  output logic                           sync_output_second
);
  import label_tag_pkg::*;
  localparam int FW = DATA_W + TAG_W + 8;

  // ****************************************
  // Configuration registers
  // ****************************************
  label_mode_t      start_mode;
  logic             second_run;
  logic             second_ext;
  logic [4:0]       out_cfg;
  logic [CNT_W-1:0] start_cnt;
  logic [CNT_W-1:0] second_cnt;
  wire  wr_start  = reg_write && (reg_addr == REG_START_MODE);
  wire  wr_second = reg_write && (reg_addr == REG_SECOND_CTL);
  wire  wr_out    = reg_write && (reg_addr == REG_OUT_CFG);
  wire  wr_cmd    = reg_write && (reg_addr == REG_COMMAND);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_mode <= label_mode_t'(START_MODE_RST);
      second_run <= 1'b0;
      second_ext <= 1'b0;
      out_cfg    <= OUT_CFG_RST;
    end else begin
      if (wr_start) begin
        start_mode <= label_mode_t'(reg_wdata[1:0]);
      end
      if (wr_second) begin
        second_run <= reg_wdata[SECOND_RUN_BIT];
        second_ext <= reg_wdata[SECOND_EXT_BIT];
      end
      if (wr_out) begin
        out_cfg <= reg_wdata[4:0];
      end
    end
  end

  // ****************************************
  // Event sources
  // ****************************************
  logic [1:0] in1_sync;
  logic [1:0] in2_sync;
  logic       in1_last;
  logic       in2_last;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in1_sync <= 2'b00;
      in2_sync <= 2'b00;
      in1_last <= 1'b0;
      in2_last <= 1'b0;
    end else begin
      in1_sync <= {in1_sync[0], sync_input_first};
      in2_sync <= {in2_sync[0], sync_input_second};
      in1_last <= in1_sync[1];
      in2_last <= in2_sync[1];
    end
  end
  wire in1_rise = in1_sync[1] && !in1_last;
  wire in2_rise = in2_sync[1] && !in2_last;
  // Internal command only counts in internal mode
  wire start_ev = (start_mode == label_mode_internal
                   && wr_cmd && reg_wdata[CMD_START_BIT])
                || (start_mode == label_mode_ext_in1_rising
                   && in1_rise);
  wire second_ev = second_run && (second_ext ? in2_rise
                   : (wr_cmd && reg_wdata[CMD_SECOND_BIT]));

  // ****************************************
  // Shared label counters
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_cnt  <= CNT_RST;
      second_cnt <= CNT_RST;
    end else begin
      // Natural 16-bit wrap
      if (start_ev) begin
        start_cnt <= start_cnt + 1'b1;
      end
      if (second_ev) begin
        second_cnt <= second_cnt + 1'b1;
      end
    end
  end
  wire [TAG_W-1:0] cur_tag = {start_cnt, second_cnt};

  // ****************************************
  // Connector outputs
  // ****************************************
  function automatic logic route_fn(input logic [1:0] fn,
                                    input logic s_ev,
                                    input logic c_ev);
    return (fn == output_fn_start_label && s_ev)
        || (fn == output_fn_second_label && c_ev);
  endfunction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_output_first  <= 1'b0;
      sync_output_second <= 1'b0;
    end else begin
      // One-cycle pulse per label
      sync_output_first  <= out_cfg[OUT_EN_BIT]
        && route_fn(out_cfg[OUT0_FN_LSB+:2], start_ev, second_ev);
      sync_output_second <= out_cfg[OUT_EN_BIT]
        && route_fn(out_cfg[OUT1_FN_LSB+:2], start_ev, second_ev);
    end
  end

  // ****************************************
  // Merge and bind
  // ****************************************
  // Fixed priority: the lowest module index wins a shared cycle
  logic [N_MOD-1:0] grant;
  logic [7:0]       grant_idx;
  logic             fifo_ready;
  always_comb begin
    grant     = '0;
    grant_idx = 8'h00;
    for (int i = N_MOD-1; i >= 0; i--) begin
      if (mod_valid[i]) begin
        grant     = '0;
        grant[i]  = 1'b1;
        grant_idx = 8'(i);
      end
    end
  end
  wire           take   = |mod_valid && fifo_ready;
  // Full buffer stalls every module; words wait at their source
  assign mod_ready = fifo_ready ? grant : '0;
  // Tag bound at reception, ahead of buffering
  wire [FW-1:0] in_word = {grant_idx, cur_tag,
                           mod_data[grant_idx*DATA_W +: DATA_W]};
  logic [FW-1:0] out_word;
  tag_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (take),
    .in_ready  (fifo_ready),
    .in_data   (in_word),
    .out_valid (host_valid),
    .out_ready (host_ready),
    .out_data  (out_word)
  );
  assign host_data   = out_word[DATA_W-1:0];
  assign host_tag    = out_word[DATA_W +: TAG_W];
  assign host_module = out_word[FW-1 -: 8];

  // ****************************************
  // Register read
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    if (reg_addr == REG_START_MODE) begin
      rd_mux = {30'h0, start_mode};
    end else if (reg_addr == REG_SECOND_CTL) begin
      rd_mux = {30'h0, second_ext, second_run};
    end else if (reg_addr == REG_OUT_CFG) begin
      rd_mux = {27'h0, out_cfg};
    end else if (reg_addr == REG_COUNTS) begin
      rd_mux = cur_tag;
    end else if (reg_addr == REG_STATUS) begin
      rd_mux = {29'h0, fifo_ready, host_valid, in1_sync[1]};
    end else begin
      rd_mux = 32'h0;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 32'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_start_count;
    @(posedge clock) disable iff (!reset_n)
    start_ev |=> start_cnt == $past(start_cnt) + 16'h0001;
  endproperty
  a_start_count: assert property (p_start_count)
    else $error("start count did not step");
  property p_second_hold;
    @(posedge clock) disable iff (!reset_n)
    !second_ev |=> $stable(second_cnt);
  endproperty
  a_second_hold: assert property (p_second_hold)
    else $error("second count moved without event");
  property p_off_quiet;
    @(posedge clock) disable iff (!reset_n)
    start_mode == label_mode_off |-> !start_ev;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("start label in off mode");
  property p_internal_cmd;
    @(posedge clock) disable iff (!reset_n)
    start_mode == label_mode_internal && start_ev |-> wr_cmd;
  endproperty
  a_internal_cmd: assert property (p_internal_cmd)
    else $error("internal label without command");
  property p_ext_edge;
    @(posedge clock) disable iff (!reset_n)
    start_mode == label_mode_ext_in1_rising && in1_rise |=>
      start_cnt != $past(start_cnt);
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("input edge missed");
  property p_out_gate;
    @(posedge clock) disable iff (!reset_n)
    !out_cfg[OUT_EN_BIT] |=> !sync_output_first && !sync_output_second;
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("unconfigured output pulsed");
  property p_out_route;
    @(posedge clock) disable iff (!reset_n)
    out_cfg[OUT_EN_BIT] && start_ev
      && out_cfg[OUT0_FN_LSB+:2] == output_fn_start_label
      |=> sync_output_first;
  endproperty
  a_out_route: assert property (p_out_route)
    else $error("start label not forwarded");
  property p_tag_bind;
    @(posedge clock) disable iff (!reset_n)
    take |-> in_word[DATA_W +: TAG_W] == {start_cnt, second_cnt};
  endproperty
  a_tag_bind: assert property (p_tag_bind)
    else $error("tag not bound at reception");
  property p_one_grant;
    @(posedge clock) disable iff (!reset_n)
    $onehot0(mod_ready);
  endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("two words taken at once");
  property p_second_ext_edge;
    @(posedge clock) disable iff (!reset_n)
    second_run && second_ext && in2_rise |=>
      second_cnt != $past(second_cnt);
  endproperty
  a_second_ext_edge: assert property (p_second_ext_edge)
    else $error("second input edge missed");
  property p_second_stopped;
    @(posedge clock) disable iff (!reset_n)
    !second_run |-> !second_ev;
  endproperty
  a_second_stopped: assert property (p_second_stopped)
    else $error("second label while stopped");
  property p_out1_route;
    @(posedge clock) disable iff (!reset_n)
    out_cfg[OUT_EN_BIT] && second_ev
      && out_cfg[OUT1_FN_LSB+:2] == output_fn_second_label
      |=> sync_output_second;
  endproperty
  a_out1_route: assert property (p_out1_route)
    else $error("second label not forwarded");
  property p_ext_only_edge;
    @(posedge clock) disable iff (!reset_n)
    start_mode == label_mode_ext_in1_rising && !in1_rise |-> !start_ev;
  endproperty
  a_ext_only_edge: assert property (p_ext_only_edge)
    else $error("start label without input edge");
  property p_host_hold;
    @(posedge clock) disable iff (!reset_n)
    host_valid && !host_ready |=>
      host_valid && $stable(host_data) && $stable(host_tag);
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host word changed while stalled");
  property p_take_one;
    @(posedge clock) disable iff (!reset_n)
    take |-> $onehot(mod_ready);
  endproperty
  a_take_one: assert property (p_take_one)
    else $error("accepted word without single grant");
  c_start: cover property (@(posedge clock) start_ev);
  c_second: cover property (@(posedge clock) second_ev && take);
  c_full: cover property (@(posedge clock) !fifo_ready);
  c_fwd: cover property (@(posedge clock) sync_output_second);
  c_ext: cover property (@(posedge clock)
    start_mode == label_mode_ext_in1_rising && in1_rise);
endmodule

//--- sim/mod_source_model.sv
`timescale 1ns/1ps
module mod_source_model #(
  parameter int N_MOD  = 4,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  // Bench control
  input  wire logic                    run,
  input  wire logic                    hold,
  // Module words
  input  wire logic [N_MOD-1:0]        mod_ready,
  output logic      [N_MOD-1:0]        mod_valid,
  output logic      [N_MOD*DATA_W-1:0] mod_data,
  // Host stream
  output logic                         host_ready
);
  int seed = 93;
  // A raised word stays put until taken, even after run drops
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mod_valid  <= '0;
      mod_data   <= '0;
      host_ready <= 1'b0;
    end else begin
      host_ready <= !hold && ($random(seed) % 4 != 0);
      for (int i = 0; i < N_MOD; i++) begin
        if (!mod_valid[i] || mod_ready[i]) begin
          mod_valid[i] <= run && $random(seed) % 2;
          mod_data[i*DATA_W+:DATA_W] <= $random(seed);
        end
      end
    end
  end
endmodule

//--- sim/sync_label_tagger_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module sync_label_tagger_tb_top;
  import label_tag_pkg::*;
  localparam int N = 4;
  logic          clock = 1'b0;
  logic          reset_n, reg_write, reg_read, host_valid, host_ready;
  logic [3:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, host_data, host_tag;
  logic [N-1:0]  mod_valid, mod_ready;
  logic [N*32-1:0] mod_data;
  logic [7:0]    host_module;
  logic          sync_input_first, sync_input_second;
  logic          sync_output_first, sync_output_second, run, hold;
  // Reference state
  logic [15:0]   sc = 16'h0000, cc = 16'h0000;
  logic [1:0]    smode = 2'h0, sctl = 2'h0;
  logic [4:0]    ocfg = 5'h00;
  int            p0 = 0, p1 = 0, e0 = 0, e1 = 0, acc = 0, k;
  int            err_count = 0, cmp_count = 0;
  logic [31:0]   q_d[$], q_t[$];
  logic [7:0]    q_m[$];

  always #5 clock = ~clock;

  sync_label_tagger #(.N_MOD(N), .DATA_W(32), .DEPTH(32)) dut_u (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .mod_valid(mod_valid), .mod_data(mod_data),
    .mod_ready(mod_ready), .host_valid(host_valid),
    .host_ready(host_ready), .host_data(host_data), .host_tag(host_tag),
    .host_module(host_module), .sync_input_first(sync_input_first),
    .sync_input_second(sync_input_second),
    .sync_output_first(sync_output_first),
    .sync_output_second(sync_output_second));

  mod_source_model #(.N_MOD(N), .DATA_W(32)) src_u (
    .clock(clock), .reset_n(reset_n), .run(run), .hold(hold),
    .mod_ready(mod_ready), .mod_valid(mod_valid), .mod_data(mod_data),
    .host_ready(host_ready));

  // Tags bound at the moment each word is taken
  always @(posedge clock) begin
    if (sync_output_first === 1'b1) p0++;
    if (sync_output_second === 1'b1) p1++;
    if (reset_n) begin
      for (int i = 0; i < N; i++) begin
        if (mod_valid[i] && mod_ready[i] === 1'b1) begin
          q_d.push_back(mod_data[i*32+:32]);
          q_m.push_back(8'(i));
          q_t.push_back({sc, cc});
          acc++;
        end
      end
      if (host_valid === 1'b1 && host_ready) begin
        `CHK(q_d.size() > 0, 1'b1)
        if (q_d.size() > 0) begin
          `CHK(host_data, q_d.pop_front())
          `CHK(host_module, q_m.pop_front())
          `CHK(host_tag, q_t.pop_front())
        end
      end
    end
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    if (a == REG_START_MODE) smode = d[1:0];
    if (a == REG_SECOND_CTL) sctl = d[1:0];
    if (a == REG_OUT_CFG) ocfg = d[4:0];
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clock);
  endtask

  // Expected counts and routed pulses for one event of each kind
  task automatic bump(input logic s, input logic c);
    if (s) sc++;
    if (c) cc++;
    if (ocfg[0] && ((s && ocfg[2:1] == 2'h1) || (c && ocfg[2:1] == 2'h2)))
      e0++;
    if (ocfg[0] && ((s && ocfg[4:3] == 2'h1) || (c && ocfg[4:3] == 2'h2)))
      e1++;
    repeat (5) @(posedge clock);
    rd(REG_COUNTS, {sc, cc});
    `CHK(p0, e0)
    `CHK(p1, e1)
  endtask

  task automatic ev(input logic [1:0] b);
    wr(REG_COMMAND, {30'h0, b});
    bump(b[0] && smode == 2'h1, b[1] && sctl == 2'h1);
  endtask

  task automatic pin(input logic first);
    if (first) sync_input_first <= 1'b1;
    else sync_input_second <= 1'b1;
    repeat (4) @(posedge clock);
    sync_input_first  <= 1'b0;
    sync_input_second <= 1'b0;
    bump(first && smode == 2'h3, !first && sctl == 2'h3);
  endtask

  task automatic idle;
    for (k = 0; k < 600 && (mod_valid != 0 || q_d.size() != 0); k++)
      @(posedge clock);
    `CHK(q_d.size(), 0)
  endtask

  initial begin
    reset_n = 1'b0;
    {reg_write, reg_read, run, hold} = 4'h0;
    {sync_input_first, sync_input_second} = 2'h0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(REG_OUT_CFG, 32'h0);
    rd(REG_COMMAND, 32'h0);
    rd(4'hF, 32'h0);
    rd(REG_STATUS, 32'h4);
    wr(REG_START_MODE, 32'h0);
    ev(2'h3);
    wr(REG_START_MODE, 32'h1);
    ev(2'h1);
    wr(REG_SECOND_CTL, 32'h1);
    ev(2'h3);
    wr(REG_OUT_CFG, 32'h13);
    rd(REG_OUT_CFG, 32'h13);
    ev(2'h3);
    wr(REG_SECOND_CTL, 32'h0);
    ev(2'h2);
    wr(REG_START_MODE, 32'h3);
    wr(REG_SECOND_CTL, 32'h3);
    wr(REG_OUT_CFG, 32'h0D);
    pin(1'b1);
    pin(1'b0);
    ev(2'h1);
    wr(REG_START_MODE, 32'h1);
    wr(REG_SECOND_CTL, 32'h1);
    // Slaves of traffic run first, labels only between bursts
    repeat (4) begin
      run <= 1'b1;
      repeat (80) @(posedge clock);
      run <= 1'b0;
      idle();
      ev(2'h3);
    end
    // Host stalls until the buffer refuses, then drains
    hold <= 1'b1;
    repeat (3) @(posedge clock);
    acc = 0;
    run <= 1'b1;
    for (k = 0; k < 400 &&
         !(acc > 0 && mod_valid != '0 && mod_ready === '0); k++)
      @(posedge clock);
    repeat (3) @(posedge clock);
    `CHK(acc, 32)
    run  <= 1'b0;
    hold <= 1'b0;
    idle();
    close_out();
  end

  initial begin
    #(20000 * 10);
    err_count++;
    close_out();
  end
endmodule
